// File: design/uart_cfg.svh
/*
  Addresses, bit positions and counts of the serial buffer, status and control block.
  Assumes inclusion by name from the package and the design modules.
*/
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define ADDR_DATA_IO 8'h0C
`define IO_MEM_OFS 8'h20
`define ADDR_CTL_B 8'h9A
`define ADDR_STAT_A 8'h9B
`define ST_RXC 7
`define ST_TXC 6
`define ST_UDRE 5
`define ST_FE 4
`define ST_DOR 3
`define ST_PE 2
`define ST_U2X 1
`define ST_MPCM 0
`define CB_RX_DONE_INTERRUPT_ON 7
`define CB_TXCIE 6
`define CB_UDRIE 5
`define CB_RXEN 4
`define CB_TXEN 3
`define CB_SZ2 2
`define CB_RXB8 1
`define CB_TXB8 0
`define SPB_NORMAL 5'h10
`define SPB_DOUBLE 5'h08
`define SIZE_NINE 3'h7
`define SIZE_HI 2
`define NBITS_MIN 4'h5
`define NBITS_EIGHT 4'h8
`define NBITS_NINE 4'h9
`define PAR_ON 1
`define PAR_ODD 0
`define E_NINTH 8
`define E_FE 9
`define E_PE 10
`define E_DOR 11
`define ENTRY_W 12
`define TXW 9
`define BAUD_W 12
`define TX_DEPTH 4
`define RX_DEPTH 2
`endif

// File: design/uart_pkg.sv
/*
  Types of the serial buffer, status and control block: state enums and the state record.
  Assumes uart_cfg.svh is on the include path.
*/
`include "uart_cfg.svh"
package uart_pkg;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } rx_state_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } tx_state_t;

  typedef struct packed {
    rx_state_t rx_st;
    logic [4:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic rx_par;
    logic hold_v;
    logic [`ENTRY_W-1:0] hold;
    tx_state_t tx_st;
    logic [4:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_sh;
    logic tx_par;
    logic tx_on;
    logic txd;
    logic [`BAUD_W-1:0] pre;
    logic txc;
    logic u2x;
    logic mpcm;
    logic rx_done_interrupt_on;
    logic txcie;
    logic udrie;
    logic rxen;
    logic txen;
    logic sz2;
    logic txb8;
    logic [7:0] rdata;
    logic irq_rx;
    logic irq_tx;
    logic irq_udre;
  } uart_state_t;
endpackage : uart_pkg

// File: design/sync_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides and a flush.
  Assumes DEPTH is a power of two; one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module sync_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;
  fifo_state_t f_r;
  fifo_state_t f_nxt;
  logic push;
  logic pop;

  assign in_ready = (f_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (f_r.cnt != '0);
  assign out_data = f_r.mem[f_r.rp];

  always_comb
  begin
    f_nxt = f_r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push)
    begin
      f_nxt.mem[f_r.wp] = in_data;
      f_nxt.wp = f_r.wp + AW'(1);
    end
    if (pop)
      f_nxt.rp = f_r.rp + AW'(1);
    if (push && !pop)
      f_nxt.cnt = f_r.cnt + (AW+1)'(1);
    else if (pop && !push)
      f_nxt.cnt = f_r.cnt - (AW+1)'(1);
    if (flush)
    begin
      f_nxt.wp = '0;
      f_nxt.rp = '0;
      f_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      f_r <= '0;
    else
      f_r <= f_nxt;
  end
endmodule : sync_fifo

// File: design/rx_pin_sync.sv
/*
  Three-stage synchroniser for the receive pin; level follows once stages two and three agree.
  Assumes an idle-high serial line.
*/
`timescale 1ns/1ps
module rx_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } pin_sync_t;
  pin_sync_t p_r;
  pin_sync_t p_nxt;

  assign level = p_r.lvl;

  always_comb
  begin
    p_nxt = p_r;
    p_nxt.s1 = pin;
    p_nxt.s2 = p_r.s1;
    p_nxt.s3 = p_r.s2;
    if (p_r.s2 == p_r.s3)
      p_nxt.lvl = p_r.s3;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      p_r <= 4'hF;
    else
      p_r <= p_nxt;
  end
endmodule : rx_pin_sync

// File: design/uart_buffer_status_control.sv
/*
  Software-visible serial transceiver: shared data location, receive queue, status A,
  control B, transmitter and receiver shifters.
  Assumes a CPU I/O bus with one-cycle read/write strobes; baud divisor and format
  settings arrive as plain inputs from outside.
*/
// Functional notes
// - Shared data address: writes go to transmit buffer, reads return oldest received.
// - Short characters: transmitter ignores high bits, receiver returns them zero.
// - Data writes while buffer-empty flag is clear are dropped.
// - Enabled transmitter moves buffered data into empty shifter, then shifts out.
// - Two-entry receive queue advances on every read of the data location.
// - Receive-complete bit 7 shows unread data; receiver disable flushes it.
// - Transmit-complete bit 6 sets when frame ends with nothing buffered.
// - Buffer-empty bit 5 shows free transmit room and is one after reset.
// - Frame-error bit 4 reports zero first stop bit of oldest character.
// - Overrun bit 3 sets on new start with queue and shifter full.
// - Parity-error bit 2 reports failed parity of oldest character.
// - Double-speed bit cuts the divisor from 16 to 8, asynchronous only.
// - Multiprocessor mode drops frames without address information at the receiver.
// - Each interrupt needs its enable, global enable and its flag.
// - Receiver enable takes the receive pin; disable flushes queue and errors.
// - Transmitter disable waits until shifter and buffer are empty.
// - Control B bit 2 is the top character-size bit for both directions.
// - Received ninth bit readable in control B bit 1.
// - Ninth transmit bit comes from control B bit 0.
// - Low I/O registers also answer at offset plus 0x20; extended ones data-space only.
// - Size codes 000 to 011 give 5 to 8 bits, 111 gives nine.
// - Parity field: 00 off, 10 even, 11 odd; generated and checked.
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_buffer_status_control #(
  parameter int TX_DEPTH = `TX_DEPTH,
  parameter int RX_DEPTH = `RX_DEPTH
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] io_addr,
  input wire logic io_is_io,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic gie,
  input wire logic txc_irq_ack,
  input wire logic [`BAUD_W-1:0] baud_div,
  input wire logic [1:0] char_size_low_bits,
  input wire logic [1:0] parity_mode,
  input wire logic stop_two,
  input wire logic sync_mode_select,
  input wire logic receive_pin,
  output logic transmit_pin,
  output logic tx_pin_own,
  output logic rx_pin_own,
  output logic rx_done_irq,
  output logic tx_done_irq,
  output logic empty_irq
);
  uart_pkg::uart_state_t st_r;
  uart_pkg::uart_state_t st_nxt;
  logic rx_in;
  logic tick;
  logic [4:0] spb;
  logic [4:0] half;
  logic [2:0] size;
  logic [3:0] nbits;
  logic par_on;
  logic acc_data;
  logic acc_ctl;
  logic acc_st;
  logic tx_push;
  logic tx_pop;
  logic rx_pop;
  logic tx_end;
  logic rx_end;
  logic rx_mid;
  logic rx_store;
  logic rx_addr;
  logic [7:0] rd;
  logic t_ready;
  logic t_valid;
  logic [`TXW-1:0] t_data;
  logic q_ready;
  logic q_valid;
  logic [`ENTRY_W-1:0] q_data;

  assign io_rdata = st_r.rdata;
  assign transmit_pin = st_r.txd;
  assign tx_pin_own = st_r.tx_on;
  assign rx_pin_own = st_r.rxen;
  assign rx_done_irq = st_r.irq_rx;
  assign tx_done_irq = st_r.irq_tx;
  assign empty_irq = st_r.irq_udre;

  rx_pin_sync rx_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .pin(receive_pin),
    .level(rx_in)
  );

  // Transmit buffer; a full buffer refuses the write outright
  sync_fifo #(.W(`TXW), .DEPTH(TX_DEPTH)) tx_buf (
    .clk(mclk),
    .rst_n(rst_n),
    .flush(1'b0),
    .in_valid(tx_push),
    .in_ready(t_ready),
    .in_data({st_r.txb8, io_wdata}),
    .out_valid(t_valid),
    .out_ready(tx_pop),
    .out_data(t_data)
  );

  // Receive queue of entries {overrun, parity, frame, ninth bit, data}
  sync_fifo #(.W(`ENTRY_W), .DEPTH(RX_DEPTH)) rx_queue (
    .clk(mclk),
    .rst_n(rst_n),
    .flush(!st_r.rxen),
    .in_valid(st_r.hold_v),
    .in_ready(q_ready),
    .in_data(st_r.hold),
    .out_valid(q_valid),
    .out_ready(rx_pop),
    .out_data(q_data)
  );

  always_comb
  begin
    st_nxt = st_r;
    tick = (st_r.pre == '0);
    st_nxt.pre = tick ? baud_div : st_r.pre - `BAUD_W'(1);
    spb = (st_r.u2x && !sync_mode_select) ? `SPB_DOUBLE : `SPB_NORMAL;
    half = spb >> 1;
    size = {st_r.sz2, char_size_low_bits};
    if (!size[`SIZE_HI])
      nbits = `NBITS_MIN + {2'b00, size[1:0]};
    else if (size == `SIZE_NINE)
      nbits = `NBITS_NINE;
    else
      nbits = `NBITS_EIGHT; // Reserved codes behave as eight bits
    par_on = parity_mode[`PAR_ON];
    acc_data = io_is_io ? (io_addr == `ADDR_DATA_IO) : (io_addr == `ADDR_DATA_IO + `IO_MEM_OFS);
    acc_ctl = !io_is_io && (io_addr == `ADDR_CTL_B);
    acc_st = !io_is_io && (io_addr == `ADDR_STAT_A);
    tx_push = io_wr && acc_data;
    rx_pop = io_rd && acc_data && q_valid;
    tx_pop = 1'b0;
    rx_store = 1'b0;
    rx_addr = 1'b0;
    tx_end = tick && (st_r.tx_cnt == spb - 5'h01);
    rx_end = tick && (st_r.rx_cnt == spb - 5'h01);
    rx_mid = tick && (st_r.rx_cnt == half - 5'h01);

    // Register writes
    if (io_wr && acc_ctl)
    begin
      st_nxt.rx_done_interrupt_on = io_wdata[`CB_RX_DONE_INTERRUPT_ON];
      st_nxt.txcie = io_wdata[`CB_TXCIE];
      st_nxt.udrie = io_wdata[`CB_UDRIE];
      st_nxt.rxen = io_wdata[`CB_RXEN];
      st_nxt.txen = io_wdata[`CB_TXEN];
      st_nxt.sz2 = io_wdata[`CB_SZ2];
      st_nxt.txb8 = io_wdata[`CB_TXB8];
    end
    // Error positions are read-only here, so stray ones written there do no harm
    if (io_wr && acc_st)
    begin
      st_nxt.u2x = io_wdata[`ST_U2X];
      st_nxt.mpcm = io_wdata[`ST_MPCM];
      if (io_wdata[`ST_TXC])
        st_nxt.txc = 1'b0;
    end
    if (txc_irq_ack)
      st_nxt.txc = 1'b0;

    // Register reads; error bits follow the oldest entry
    rd = 8'h00;
    if (acc_data && q_valid)
      rd = q_data[7:0];
    if (acc_st)
    begin
      rd[`ST_RXC] = q_valid;
      rd[`ST_TXC] = st_r.txc;
      rd[`ST_UDRE] = t_ready;
      rd[`ST_FE] = q_valid & q_data[`E_FE];
      rd[`ST_DOR] = q_valid & q_data[`E_DOR];
      rd[`ST_PE] = q_valid & q_data[`E_PE];
      rd[`ST_U2X] = st_r.u2x;
      rd[`ST_MPCM] = st_r.mpcm;
    end
    if (acc_ctl)
    begin
      rd[`CB_RX_DONE_INTERRUPT_ON] = st_r.rx_done_interrupt_on;
      rd[`CB_TXCIE] = st_r.txcie;
      rd[`CB_UDRIE] = st_r.udrie;
      rd[`CB_RXEN] = st_r.rxen;
      rd[`CB_TXEN] = st_r.txen;
      rd[`CB_SZ2] = st_r.sz2;
      rd[`CB_RXB8] = q_valid & q_data[`E_NINTH];
      rd[`CB_TXB8] = st_r.txb8;
    end
    if (io_rd)
      st_nxt.rdata = rd;

    // Transmitter
    if (tick)
      st_nxt.tx_cnt = tx_end ? 5'h00 : st_r.tx_cnt + 5'h01;
    case (st_r.tx_st)
      uart_pkg::TX_IDLE:
      begin
        st_nxt.txd = 1'b1;
        if (st_r.tx_on && t_valid)
        begin
          tx_pop = 1'b1;
          st_nxt.tx_sh = t_data;
          st_nxt.tx_par = 1'b0;
          st_nxt.tx_cnt = 5'h00;
          st_nxt.txd = 1'b0;
          st_nxt.tx_st = uart_pkg::TX_START;
        end
      end
      uart_pkg::TX_START:
      begin
        if (tx_end)
        begin
          st_nxt.tx_bit = 4'h0;
          st_nxt.txd = st_r.tx_sh[0];
          st_nxt.tx_st = uart_pkg::TX_DATA;
        end
      end
      uart_pkg::TX_DATA:
      begin
        if (tx_end)
        begin
          st_nxt.tx_par = st_r.tx_par ^ st_r.tx_sh[st_r.tx_bit];
          if (st_r.tx_bit == nbits - 4'h1)
          begin
            st_nxt.tx_bit = 4'h0;
            if (par_on)
            begin
              st_nxt.txd = st_r.tx_par ^ st_r.tx_sh[st_r.tx_bit] ^ parity_mode[`PAR_ODD];
              st_nxt.tx_st = uart_pkg::TX_PAR;
            end
            else
            begin
              st_nxt.txd = 1'b1;
              st_nxt.tx_st = uart_pkg::TX_STOP;
            end
          end
          else
          begin
            st_nxt.tx_bit = st_r.tx_bit + 4'h1;
            st_nxt.txd = st_r.tx_sh[st_r.tx_bit + 4'h1];
          end
        end
      end
      uart_pkg::TX_PAR:
      begin
        if (tx_end)
        begin
          st_nxt.txd = 1'b1;
          st_nxt.tx_st = uart_pkg::TX_STOP;
        end
      end
      uart_pkg::TX_STOP:
      begin
        if (tx_end)
        begin
          if (stop_two && st_r.tx_bit == 4'h0)
            st_nxt.tx_bit = 4'h1;
          else
          begin
            st_nxt.tx_st = uart_pkg::TX_IDLE;
            if (!t_valid)
              st_nxt.txc = 1'b1;
          end
        end
      end
      default:
      begin
        st_nxt.txd = 1'b1;
        st_nxt.tx_st = uart_pkg::TX_IDLE;
      end
    endcase
    // Pin stays owned until the last pending frame is out
    st_nxt.tx_on = st_r.txen | (st_r.tx_on & ((st_r.tx_st != uart_pkg::TX_IDLE) | t_valid));

    // Receiver; the held character drains into the queue when room appears
    st_nxt.hold_v = st_r.hold_v & ~q_ready;
    if (tick)
      st_nxt.rx_cnt = (rx_end || rx_mid && st_r.rx_st == uart_pkg::RX_START) ? 5'h00 : st_r.rx_cnt + 5'h01;
    case (st_r.rx_st)
      uart_pkg::RX_IDLE:
      begin
        if (!rx_in)
        begin
          st_nxt.rx_cnt = 5'h00;
          st_nxt.rx_st = uart_pkg::RX_START;
          if (st_r.hold_v && !q_ready)
            st_nxt.hold[`E_DOR] = 1'b1;
        end
      end
      uart_pkg::RX_START:
      begin
        // Glitch shorter than half a bit is not a start
        if (rx_mid)
        begin
          st_nxt.rx_bit = 4'h0;
          st_nxt.rx_sh = 9'h000;
          st_nxt.rx_par = 1'b0;
          st_nxt.rx_st = rx_in ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
        end
      end
      uart_pkg::RX_DATA:
      begin
        if (rx_end)
        begin
          st_nxt.rx_sh[st_r.rx_bit] = rx_in;
          st_nxt.rx_par = st_r.rx_par ^ rx_in;
          if (st_r.rx_bit == nbits - 4'h1)
            st_nxt.rx_st = par_on ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
          else
            st_nxt.rx_bit = st_r.rx_bit + 4'h1;
        end
      end
      uart_pkg::RX_PAR:
      begin
        if (rx_end)
        begin
          st_nxt.rx_par = st_r.rx_par ^ rx_in;
          st_nxt.rx_st = uart_pkg::RX_STOP;
        end
      end
      uart_pkg::RX_STOP:
      begin
        if (rx_end)
        begin
          st_nxt.rx_st = uart_pkg::RX_IDLE;
          rx_addr = st_r.rx_sh[nbits - 4'h1];
          rx_store = !(st_r.mpcm && !rx_addr);
        end
      end
      default:
        st_nxt.rx_st = uart_pkg::RX_IDLE;
    endcase
    // A frame finishing while the shifter still holds one is lost
    if (rx_store && !st_nxt.hold_v)
    begin
      st_nxt.hold_v = 1'b1;
      st_nxt.hold = {1'b0, par_on & (st_r.rx_par ^ parity_mode[`PAR_ODD]), !rx_in, st_r.rx_sh};
    end
    if (!st_r.rxen)
    begin
      st_nxt.rx_st = uart_pkg::RX_IDLE;
      st_nxt.hold_v = 1'b0;
    end

    st_nxt.irq_rx = st_r.rx_done_interrupt_on & gie & q_valid;
    st_nxt.irq_tx = st_r.txcie & gie & st_r.txc;
    st_nxt.irq_udre = st_r.udrie & gie & t_ready;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.txd <= 1'b1;
      st_r.rx_st <= uart_pkg::RX_IDLE;
      st_r.tx_st <= uart_pkg::TX_IDLE;
    end
    else
      st_r <= st_nxt;
  end
endmodule : uart_buffer_status_control

// File: verification/uart_bsc_props.sv
/*
  Port checker for the serial buffer, status and control block.
  Assumes one clock, mclk, and synchronous active-low rst_n; bound at the end of this file.
*/
`timescale 1ns/1ps
module uart_bsc_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] io_addr,
  input wire logic io_is_io,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic gie,
  input wire logic transmit_pin,
  input wire logic tx_pin_own,
  input wire logic rx_pin_own,
  input wire logic rx_done_irq,
  input wire logic tx_done_irq,
  input wire logic empty_irq
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic ctl_wr;
  assign ctl_wr = io_wr && !io_is_io && io_addr == 8'h9A;
  rx_irq_gate_a: assert property (rx_done_irq |-> $past(gie))
    else $error("rx done irq without global enable");
  tx_irq_gate_a: assert property (tx_done_irq |-> $past(gie))
    else $error("tx done irq without global enable");
  empty_irq_gate_a: assert property (empty_irq |-> $past(gie))
    else $error("empty irq without global enable");
  rdata_hold_a: assert property (!$past(io_rd) |-> $stable(io_rdata))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (io_rd && io_is_io && io_addr != 8'h0C |=> io_rdata == 8'h00)
    else $error("unmapped io read not zero");
  rx_own_follow_a: assert property (ctl_wr ##1 !ctl_wr |=> rx_pin_own == $past(io_wdata[4], 2))
    else $error("receive pin ownership not following enable");
  tx_own_on_a: assert property (ctl_wr && io_wdata[3] |-> ##[1:2] tx_pin_own)
    else $error("transmitter did not take the pin");
  tx_idle_high_a: assert property (!tx_pin_own |-> transmit_pin)
    else $error("transmit pin low while not owned");
  start_width_a: assert property ($fell(transmit_pin) |-> (!transmit_pin) [*8])
    else $error("start bit shorter than eight clocks");
  rx_irq_c: cover property (rx_done_irq);
  tx_frame_c: cover property ($fell(transmit_pin));
  tx_own_c: cover property (!tx_pin_own ##1 tx_pin_own);
endmodule : uart_bsc_props

bind uart_buffer_status_control uart_bsc_props uart_bsc_props_i (
  .mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_is_io(io_is_io), .io_rd(io_rd), .io_wr(io_wr),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .gie(gie), .transmit_pin(transmit_pin),
  .tx_pin_own(tx_pin_own), .rx_pin_own(rx_pin_own), .rx_done_irq(rx_done_irq),
  .tx_done_irq(tx_done_irq), .empty_irq(empty_irq)
);

// File: verification/serial_node.sv
/*
  Remote serial node: sends frames towards the block and samples frames from it.
  Assumes the bench calls its tasks just after a clock edge; idle-high line.
*/
`timescale 1ns/1ps
module serial_node (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // Start, nb data bits LSB first, one stop of given level, then one idle bit
  task automatic send(input logic [8:0] dat, input int nb, input logic stop, input int bc);
    for (int i = -1; i <= nb; i++)
    begin
      line_out = (i < 0) ? 1'b0 : (i < nb) ? dat[i] : stop;
      repeat (bc) @(posedge clk);
      #1;
    end
    line_out = 1'b1;
    repeat (bc) @(posedge clk);
    #1;
  endtask : send
  // Ok only when a frame started within the wait and its stop read high
  task automatic recv(output logic [8:0] dat, output logic ok, input int nb, input int bc);
    int n;
    dat = 9'h000;
    n = 0;
    while (line_in !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = (n < 400);
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i <= nb; i++)
    begin
      repeat (bc) @(posedge clk);
      if (i < nb)
        dat[i] = line_in;
      else
        ok = ok && (line_in === 1'b1);
    end
    #1;
  endtask : recv
endmodule : serial_node

// File: verification/testbench.sv
/*
  Self-checking bench for the serial buffer, status and control block.
  Assumes design, package, header, node model and checker are compiled first.
*/
`timescale 1ns/1ps
`include "uart_cfg.svh"
module testbench;
  logic mclk, rst_n, io_is_io, io_rd, io_wr, gie, txc_irq_ack, stop_two, sync_mode_select;
  logic [7:0] io_addr, io_wdata, io_rdata, v;
  logic [`BAUD_W-1:0] baud_div;
  logic [1:0] char_size_low_bits, parity_mode;
  logic transmit_pin, tx_pin_own, rx_pin_own, rx_done_irq, tx_done_irq, empty_irq, node_line, ok;
  logic [8:0] d;
  int n_fail = 0;
  int checks = 0;
  uart_buffer_status_control uart_buffer_status_control_i (
    .mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_is_io(io_is_io), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .gie(gie), .txc_irq_ack(txc_irq_ack),
    .baud_div(baud_div), .char_size_low_bits(char_size_low_bits), .parity_mode(parity_mode),
    .stop_two(stop_two), .sync_mode_select(sync_mode_select), .receive_pin(node_line),
    .transmit_pin(transmit_pin), .tx_pin_own(tx_pin_own), .rx_pin_own(rx_pin_own),
    .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq), .empty_irq(empty_irq)
  );
  serial_node serial_node_i (.clk(mclk), .line_in(transmit_pin), .line_out(node_line));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] dat);
    cyc(1);
    io_is_io = io;
    io_addr = a;
    io_wdata = dat;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
  endtask : wr
  // Read data lands at the strobe's edge, so it is taken just after it
  task automatic rd(input logic io, input logic [7:0] a);
    cyc(1);
    io_is_io = io;
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    v = io_rdata;
  endtask : rd
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic t_regs;
    rd(1'b0, 8'h9B);
    chk(v, 9'h020);
    rd(1'b0, 8'h9A);
    chk(v, 9'h000);
    rd(1'b1, 8'h3F);
    chk(v, 9'h000);
    rd(1'b1, 8'h9A);
    chk(v, 9'h000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_tx;
    gie = 1'b1;
    wr(1'b0, 8'h9A, 8'h68);
    cyc(2);
    chk(empty_irq, 9'h1);
    fork
      serial_node_i.recv(d, ok, 8, 16);
      wr(1'b1, 8'h0C, 8'hA5);
    join
    chk(d, 9'h0A5);
    chk(ok, 9'h1);
    cyc(20);
    chk(tx_done_irq, 9'h1);
    rd(1'b0, 8'h9B);
    chk(v[6], 9'h1);
    chk(v[5], 9'h1);
    wr(1'b0, 8'h9B, 8'h40);
    rd(1'b0, 8'h9B);
    chk(v[6], 9'h0);
    wr(1'b0, 8'h9A, 8'h08);
    gie = 1'b0;
    $display("test tx done");
  endtask : t_tx
  task automatic t_fill;
    fork
      for (int i = 1; i <= 5; i++)
      begin
        serial_node_i.recv(d, ok, 8, 16);
        chk(d, 9'(17 * i));
      end
      begin
        for (int i = 1; i <= 6; i++)
        begin
          if (i == 6)
          begin
            rd(1'b0, 8'h9B);
            chk(v[5], 9'h0);
          end
          wr(1'b1, 8'h0C, 8'(17 * i));
        end
        wr(1'b0, 8'h9A, 8'h00);
        cyc(2);
        chk(tx_pin_own, 9'h1);
      end
    join
    serial_node_i.recv(d, ok, 8, 16);
    chk(ok, 9'h0);
    chk(tx_pin_own, 9'h0);
    $display("test fill done");
  endtask : t_fill
  task automatic t_short;
    char_size_low_bits = 2'h1;
    wr(1'b0, 8'h9A, 8'h18);
    fork
      serial_node_i.recv(d, ok, 6, 16);
      wr(1'b1, 8'h0C, 8'h80);
    join
    chk(d, 9'h000);
    chk(ok, 9'h1);
    serial_node_i.send(9'h0FF, 6, 1'b1, 16);
    rd(1'b0, 8'h2C);
    chk(v, 9'h03F);
    char_size_low_bits = 2'h3;
    $display("test short done");
  endtask : t_short
  task automatic t_rx;
    gie = 1'b1;
    wr(1'b0, 8'h9A, 8'h90);
    serial_node_i.send(9'h05A, 8, 1'b1, 16);
    rd(1'b0, 8'h9B);
    chk(v[7], 9'h1);
    chk(rx_done_irq, 9'h1);
    chk(rx_pin_own, 9'h1);
    serial_node_i.send(9'h03C, 8, 1'b0, 16);
    rd(1'b0, 8'h9B);
    chk(v[4], 9'h0);
    rd(1'b1, 8'h0C);
    chk(v, 9'h05A);
    rd(1'b0, 8'h9B);
    chk(v[4], 9'h1);
    rd(1'b1, 8'h0C);
    chk(v, 9'h03C);
    rd(1'b0, 8'h9B);
    chk(v[7], 9'h0);
    cyc(2);
    chk(rx_done_irq, 9'h0);
    gie = 1'b0;
    $display("test rx done");
  endtask : t_rx
  task automatic t_ovr;
    for (int i = 1; i <= 4; i++)
      serial_node_i.send(9'(i), 8, 1'b1, 16);
    for (int i = 1; i <= 2; i++)
    begin
      rd(1'b1, 8'h0C);
      chk(v, 9'(i));
    end
    rd(1'b0, 8'h9B);
    chk(v[3], 9'h1);
    rd(1'b1, 8'h0C);
    chk(v, 9'h003);
    rd(1'b0, 8'h9B);
    chk(v[7], 9'h0);
    serial_node_i.send(9'h077, 8, 1'b1, 16);
    rd(1'b0, 8'h9B);
    chk(v[7], 9'h1);
    wr(1'b0, 8'h9A, 8'h00);
    rd(1'b0, 8'h9B);
    chk(v[7], 9'h0);
    chk(rx_pin_own, 9'h0);
    $display("test overrun done");
  endtask : t_ovr
  task automatic t_nine;
    wr(1'b0, 8'h9A, 8'h1D);
    fork
      serial_node_i.recv(d, ok, 9, 16);
      wr(1'b1, 8'h0C, 8'h55);
    join
    chk(d, 9'h155);
    serial_node_i.send(9'h1AA, 9, 1'b1, 16);
    rd(1'b0, 8'h9A);
    chk(v[1], 9'h1);
    rd(1'b0, 8'h2C);
    chk(v, 9'h0AA);
    wr(1'b0, 8'h9A, 8'h00);
    $display("test nine done");
  endtask : t_nine
  // Double speed with even parity, then address filtering and the serviced-interrupt clear
  task automatic t_mode;
    parity_mode = 2'h2;
    wr(1'b0, 8'h9A, 8'h18);
    wr(1'b0, 8'h9B, 8'h02);
    fork
      serial_node_i.recv(d, ok, 9, 8);
      wr(1'b1, 8'h0C, 8'h07);
    join
    chk(d, 9'h107);
    chk(ok, 9'h1);
    serial_node_i.send(9'h007, 9, 1'b1, 8);
    rd(1'b0, 8'h9B);
    chk(v[2], 9'h1);
    chk(v[6], 9'h1);
    rd(1'b1, 8'h0C);
    chk(v, 9'h007);
    parity_mode = 2'h0;
    wr(1'b0, 8'h9B, 8'h03);
    serial_node_i.send(9'h011, 8, 1'b1, 8);
    serial_node_i.send(9'h091, 8, 1'b1, 8);
    rd(1'b1, 8'h0C);
    chk(v, 9'h091);
    txc_irq_ack = 1'b1;
    cyc(1);
    txc_irq_ack = 1'b0;
    rd(1'b0, 8'h9B);
    chk(v[6], 9'h0);
    wr(1'b0, 8'h9B, 8'h00);
    wr(1'b0, 8'h9A, 8'h00);
    $display("test mode done");
  endtask : t_mode
  initial
  begin
    rst_n = 1'b0;
    {io_is_io, io_rd, io_wr, gie, txc_irq_ack, stop_two, sync_mode_select} = 7'h00;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    baud_div = '0;
    char_size_low_bits = 2'h3;
    parity_mode = 2'h0;
    cyc(16);
    rst_n = 1'b1;
    t_regs();
    t_tx();
    t_fill();
    t_short();
    t_rx();
    t_ovr();
    t_nine();
    t_mode();
    test_done();
  end
  // Whole run is near 4000 clocks; cut off well beyond that
  initial
  begin
    #3000000;
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    test_done();
  end
endmodule : testbench
